// File: ibu_pkg.sv
/*
  Shared constants and enumerations for the index and byte instruction unit.
  Assumes a 15-bit word address space in which words 0 and 1 are the accumulators.
*/
package ibu_pkg;

  // ==========================================================================
  // Widths and fixed addresses
  // ==========================================================================
  localparam logic [14:0] ACC_A_WORD   = 15'h0000;
  localparam logic [14:0] ACC_B_WORD   = 15'h0001;
  localparam logic [14:0] ACC_WORDS    = 15'h0002;
  localparam logic [15:0] BYTE_ACC_TOP = 16'h0004;
  localparam int          INDIRECT_BIT = 15;
  localparam int          LOW_BYTE_BIT = 0;

  // ==========================================================================
  // Program counter steps and the word 3 offset, counted from the instruction's first word
  // ==========================================================================
  localparam logic [14:0] P_ONE_WORD   = 15'h0001;
  localparam logic [14:0] P_TWO_WORD   = 15'h0002;
  localparam logic [14:0] P_WORD3      = 15'h0002;
  localparam logic [14:0] P_EQUAL      = 15'h0003;
  localparam logic [14:0] P_LESS       = 15'h0004;
  localparam logic [14:0] P_GREATER    = 15'h0005;

  // ==========================================================================
  // Reset values and preload selectors
  // ==========================================================================
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [1:0]  SEL_A        = 2'h0;
  localparam logic [1:0]  SEL_B        = 2'h1;
  localparam logic [1:0]  SEL_X        = 2'h2;
  localparam logic [1:0]  SEL_Y        = 2'h3;

  // ==========================================================================
  // Decoded operations
  // ==========================================================================
  typedef enum logic [4:0] {
    OP_LOAD_SECOND_INDEX,
    OP_LOAD_B_INDEXED_SECOND,
    OP_STORE_A_INDEXED_FIRST,
    OP_STORE_A_INDEXED_SECOND,
    OP_STORE_B_INDEXED_FIRST,
    OP_STORE_B_INDEXED_SECOND,
    OP_STORE_FIRST_INDEX,
    OP_STORE_SECOND_INDEX,
    OP_SWAP_A_FIRST_INDEX,
    OP_SWAP_A_SECOND_INDEX,
    OP_SWAP_B_FIRST_INDEX,
    OP_SWAP_B_SECOND_INDEX,
    OP_SUBROUTINE_JUMP_LINK,
    OP_INDEXED_RETURN_JUMP,
    OP_BYTE_STRING_COMPARE,
    OP_LOAD_BYTE,
    OP_BYTE_BLOCK_MOVE
  } ibu_op_e;

endpackage

// File: ibu_core.sv
/*
  Execution unit for the index register, subroutine jump and byte instructions.
  Assumes a decoder hands over one command with its location and second word, and a
  single-port word memory answering with an acknowledge on the same clock.
*/
`timescale 1ns/1ps

// Function
// - Load second index from word, accumulators at 0/1.
// - Load B from operand plus second index.
// - Indexed stores write accumulator, set address register.
// - Resolve indirection first, drop effective bit 15.
// - Store index register, accumulators at 0/1.
// - Swap one accumulator with one index register.
// - Link jump targets address, second index gets P+2.
// - Jumps check target against protection fence.
// - Return jump to second index plus operand.
// - Byte address is twice word plus half.
// - Byte addresses are full sixteen bits.
// - Byte addresses 0-3 hit accumulators, never violate.
// - String compare uses three instruction words.
// - Compare unsigned bytes, stop at first difference.
// - Equal exit: no skip, A advanced by count.
// - Less skips one, greater two, A stops.
// - B always ends advanced by the count.
// - Interrupted compare saves remaining count in word 3.
// - Load byte into A low, increment B.
// - Block move ascending, both addresses incremented.
// - Move checks protection per byte, addresses wrap.
module ibu_core (
  input  wire logic            clk,        // 125 MHz clock
  input  wire logic            rst_b,      // Asynchronous reset, active low
  input  wire logic            cmd_valid,  // Start pulse for one instruction
  input  wire ibu_pkg::ibu_op_e cmd_op,    // Decoded operation
  input  wire logic [14:0]     cmd_p,      // Location of the first instruction word
  input  wire logic [15:0]     cmd_addr,   // Second instruction word
  input  wire logic            ld_en,      // Preload strobe for A, B, X or Y
  input  wire logic [1:0]      ld_sel,     // Preload target
  input  wire logic [15:0]     ld_data,    // Preload value
  input  wire logic [14:0]     fence,      // Lowest unprotected word address
  input  wire logic            protect_en, // Memory protection active
  input  wire logic            irq_req,    // Pending interrupt request
  output logic                 mem_req,    // Memory request, held until ack
  output logic                 mem_we,     // Memory write
  output logic [14:0]          mem_addr,   // Memory word address
  output logic [15:0]          mem_wdata,  // Memory write data
  input  wire logic [15:0]     mem_rdata,  // Memory read data
  input  wire logic            mem_ack,    // Memory acknowledge
  output logic                 busy,       // Instruction in progress
  output logic                 done,       // One-cycle completion pulse
  output logic                 viol,       // One-cycle protect violation pulse
  output logic                 intr_exit,  // One-cycle pulse: compare left for interrupt
  output logic [15:0]          a_reg,      // First accumulator
  output logic [15:0]          b_reg,      // Second accumulator
  output logic [15:0]          x_reg,      // First index register
  output logic [15:0]          y_reg,      // Second index register
  output logic [14:0]          p_reg,      // Program counter
  output logic [14:0]          m_reg       // Memory address register
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [4:0] {
    S_IDLE, S_IND, S_IND_GOT, S_DISPATCH, S_RD, S_WR, S_LOADW,
    S_CB_W3, S_CB_CNT, S_CB_LOOP, S_CB_B1, S_CB_B2,
    S_MV_CNT, S_MV_LOOP, S_MV_SRC, S_MV_DST, S_MV_NEXT, S_LBT, S_FIN
  } ibu_state_e;

  ibu_state_e       state_q, state_d, ret_q, ret_d;
  ibu_pkg::ibu_op_e op_q, op_d;
  logic [15:0]      a_q, a_d, b_q, b_d, x_q, x_d, y_q, y_d;
  logic [14:0]      p_q, p_d, m_q, m_d, ip_q, ip_d, maddr_q, maddr_d;
  logic [15:0]      addr_q, addr_d, data_q, data_d, cnt_q, cnt_d, w3_q, w3_d, wdata_q, wdata_d;
  logic [7:0]       byte_q, byte_d;
  logic             req_q, req_d, we_q, we_d, busy_q, busy_d;
  logic             done_q, done_d, viol_q, viol_d, intr_q, intr_d;

  // Access requests raised by the states and served by one common block below.
  logic             go_rd, go_wr;
  logic [14:0]      go_addr;
  logic [15:0]      go_wdata;
  logic [15:0]      idx_sum, x_sum, y_sum, jpy_sum;
  logic [7:0]       sel_byte;

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic lo);
    pick_byte = lo ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic lo, input logic [7:0] v);
    put_byte = lo ? {w[15:8], v} : {v, w[7:0]};
  endfunction

  assign x_sum    = addr_q + x_q;
  assign y_sum    = addr_q + y_q;
  assign jpy_sum  = cmd_addr + y_q;
  assign sel_byte = pick_byte(data_q, a_q[ibu_pkg::LOW_BYTE_BIT]);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    state_d = state_q;
    ret_d   = ret_q;
    op_d    = op_q;
    {a_d, b_d, x_d, y_d, p_d, m_d, ip_d, addr_d, data_d, cnt_d, w3_d, byte_d, req_d, we_d, maddr_d, wdata_d,
     busy_d} = {a_q, b_q, x_q, y_q, p_q, m_q, ip_q, addr_q, data_q, cnt_q, w3_q, byte_q, req_q, we_q, maddr_q,
                wdata_q, busy_q};
    {done_d, viol_d, intr_d} = 3'b000;
    {go_rd, go_wr, go_addr, go_wdata, idx_sum} = '0;

    unique case (state_q)
      S_IDLE:
      begin
        if (ld_en)
        begin
          unique case (ld_sel)
            ibu_pkg::SEL_A: a_d = ld_data;
            ibu_pkg::SEL_B: b_d = ld_data;
            ibu_pkg::SEL_X: x_d = ld_data;
            ibu_pkg::SEL_Y: y_d = ld_data;
          endcase
        end
        if (cmd_valid)
        begin
          op_d   = cmd_op;
          ip_d   = cmd_p;
          addr_d = cmd_addr;
          busy_d = 1'b1;
          unique case (cmd_op)
            ibu_pkg::OP_SWAP_A_FIRST_INDEX:  begin a_d = x_q; x_d = a_q; state_d = S_FIN; end
            ibu_pkg::OP_SWAP_A_SECOND_INDEX: begin a_d = y_q; y_d = a_q; state_d = S_FIN; end
            ibu_pkg::OP_SWAP_B_FIRST_INDEX:  begin b_d = x_q; x_d = b_q; state_d = S_FIN; end
            ibu_pkg::OP_SWAP_B_SECOND_INDEX: begin b_d = y_q; y_d = b_q; state_d = S_FIN; end
            ibu_pkg::OP_INDEXED_RETURN_JUMP: begin addr_d = jpy_sum; state_d = S_DISPATCH; end
            ibu_pkg::OP_LOAD_BYTE:           state_d = S_DISPATCH;
            default:                         state_d = S_IND;
          endcase
          if (state_d == S_FIN)
            p_d = cmd_p + ibu_pkg::P_ONE_WORD;
        end
      end

      // Every indirect level is followed to the end before any index is added.
      S_IND:
      begin
        if (addr_q[ibu_pkg::INDIRECT_BIT])
        begin
          go_rd   = 1'b1;
          go_addr = addr_q[14:0];
          ret_d   = S_IND_GOT;
        end
        else
          state_d = S_DISPATCH;
      end

      S_IND_GOT:
      begin
        addr_d  = data_q;
        state_d = S_IND;
      end

      S_DISPATCH:
      begin
        ret_d = S_FIN;
        p_d   = ip_q + ibu_pkg::P_TWO_WORD;
        unique case (op_q)
          ibu_pkg::OP_LOAD_SECOND_INDEX:
          begin
            go_rd = 1'b1; go_addr = addr_q[14:0]; ret_d = S_LOADW;
          end
          ibu_pkg::OP_LOAD_B_INDEXED_SECOND:
          begin
            m_d = y_sum[14:0]; go_rd = 1'b1; go_addr = y_sum[14:0]; ret_d = S_LOADW;
          end
          ibu_pkg::OP_STORE_A_INDEXED_FIRST, ibu_pkg::OP_STORE_A_INDEXED_SECOND,
          ibu_pkg::OP_STORE_B_INDEXED_FIRST, ibu_pkg::OP_STORE_B_INDEXED_SECOND:
          begin
            idx_sum = (op_q inside {ibu_pkg::OP_STORE_A_INDEXED_FIRST, ibu_pkg::OP_STORE_B_INDEXED_FIRST})
                      ? x_sum : y_sum;
            m_d      = idx_sum[14:0];
            go_wr    = 1'b1;
            go_addr  = idx_sum[14:0];
            go_wdata = (op_q inside {ibu_pkg::OP_STORE_A_INDEXED_FIRST, ibu_pkg::OP_STORE_A_INDEXED_SECOND})
                       ? a_q : b_q;
          end
          ibu_pkg::OP_STORE_FIRST_INDEX:
          begin
            go_wr = 1'b1; go_addr = addr_q[14:0]; go_wdata = x_q;
          end
          ibu_pkg::OP_STORE_SECOND_INDEX:
          begin
            go_wr = 1'b1; go_addr = addr_q[14:0]; go_wdata = y_q;
          end
          ibu_pkg::OP_SUBROUTINE_JUMP_LINK, ibu_pkg::OP_INDEXED_RETURN_JUMP:
          begin
            state_d = S_FIN;
            if (protect_en && (addr_q[14:0] < fence))
            begin
              viol_d = 1'b1;
              p_d    = ip_q;
            end
            else
            begin
              p_d = addr_q[14:0];
              if (op_q == ibu_pkg::OP_SUBROUTINE_JUMP_LINK)
                y_d = {1'b0, ip_q + ibu_pkg::P_TWO_WORD};
            end
          end
          ibu_pkg::OP_BYTE_STRING_COMPARE:
          begin
            go_rd = 1'b1; go_addr = ip_q + ibu_pkg::P_WORD3; ret_d = S_CB_W3;
          end
          ibu_pkg::OP_LOAD_BYTE:
          begin
            go_rd = 1'b1; go_addr = b_q[15:1]; ret_d = S_LBT;
          end
          ibu_pkg::OP_BYTE_BLOCK_MOVE:
          begin
            go_rd = 1'b1; go_addr = addr_q[14:0]; ret_d = S_MV_CNT;
          end
          default: state_d = S_FIN;
        endcase
      end

      // Writes wait here too; the data taken then is never used.
      S_RD, S_WR:
      begin
        if (mem_ack)
        begin
          req_d   = 1'b0;
          we_d    = 1'b0;
          data_d  = mem_rdata;
          state_d = ret_q;
        end
      end

      S_LOADW:
      begin
        if (op_q == ibu_pkg::OP_LOAD_SECOND_INDEX)
          y_d = data_q;
        else
          b_d = data_q;
        state_d = S_FIN;
      end

      S_CB_W3:
      begin
        w3_d  = data_q;
        go_rd = 1'b1; go_addr = addr_q[14:0]; ret_d = S_CB_CNT;
      end

      // A nonzero word 3 means the compare was interrupted and is resumed here.
      S_CB_CNT:
      begin
        cnt_d   = (w3_q != '0) ? w3_q : data_q;
        state_d = S_CB_LOOP;
      end

      S_CB_LOOP:
      begin
        if (cnt_q == '0)
        begin
          p_d   = ip_q + ibu_pkg::P_EQUAL;
          go_wr = 1'b1; go_addr = ip_q + ibu_pkg::P_WORD3; go_wdata = '0; ret_d = S_FIN;
        end
        else if (irq_req)
        begin
          p_d    = ip_q;
          intr_d = 1'b1;
          go_wr  = 1'b1; go_addr = ip_q + ibu_pkg::P_WORD3; go_wdata = cnt_q; ret_d = S_FIN;
        end
        else
        begin
          go_rd = 1'b1; go_addr = a_q[15:1]; ret_d = S_CB_B1;
        end
      end

      S_CB_B1:
      begin
        byte_d = sel_byte;
        go_rd  = 1'b1; go_addr = b_q[15:1]; ret_d = S_CB_B2;
      end

      S_CB_B2:
      begin
        if (byte_q == pick_byte(data_q, b_q[ibu_pkg::LOW_BYTE_BIT]))
        begin
          a_d     = a_q + 16'h0001;
          b_d     = b_q + 16'h0001;
          cnt_d   = cnt_q - 16'h0001;
          state_d = S_CB_LOOP;
        end
        else
        begin
          b_d   = b_q + cnt_q;
          p_d   = (byte_q < pick_byte(data_q, b_q[ibu_pkg::LOW_BYTE_BIT]))
                  ? ip_q + ibu_pkg::P_LESS : ip_q + ibu_pkg::P_GREATER;
          go_wr = 1'b1; go_addr = ip_q + ibu_pkg::P_WORD3; go_wdata = '0; ret_d = S_FIN;
        end
      end

      S_MV_CNT:
      begin
        cnt_d   = data_q;
        state_d = S_MV_LOOP;
      end

      S_MV_LOOP:
      begin
        if (cnt_q == '0)
        begin
          p_d     = ip_q + ibu_pkg::P_EQUAL;
          state_d = S_FIN;
        end
        else
        begin
          go_rd = 1'b1; go_addr = a_q[15:1]; ret_d = S_MV_SRC;
        end
      end

      // Protection is checked for each byte, except for the accumulator bytes.
      S_MV_SRC:
      begin
        byte_d = sel_byte;
        if (protect_en && (b_q >= ibu_pkg::BYTE_ACC_TOP) && (b_q[15:1] < fence))
        begin
          viol_d  = 1'b1;
          p_d     = ip_q;
          state_d = S_FIN;
        end
        else
        begin
          go_rd = 1'b1; go_addr = b_q[15:1]; ret_d = S_MV_DST;
        end
      end

      S_MV_DST:
      begin
        go_wr    = 1'b1;
        go_addr  = b_q[15:1];
        go_wdata = put_byte(data_q, b_q[ibu_pkg::LOW_BYTE_BIT], byte_q);
        ret_d    = S_MV_NEXT;
      end

      // The increment acts on whatever the move just left in A and B, so a move
      // into bytes 0 to 3 corrupts the addresses as the hardware always has.
      S_MV_NEXT:
      begin
        a_d     = a_q + 16'h0001;
        b_d     = b_q + 16'h0001;
        cnt_d   = cnt_q - 16'h0001;
        state_d = S_MV_LOOP;
      end

      S_LBT:
      begin
        a_d     = {8'h00, pick_byte(data_q, b_q[ibu_pkg::LOW_BYTE_BIT])};
        b_d     = b_q + 16'h0001;
        p_d     = ip_q + ibu_pkg::P_ONE_WORD;
        state_d = S_FIN;
      end

      S_FIN:
      begin
        done_d  = 1'b1;
        busy_d  = 1'b0;
        state_d = S_IDLE;
      end
    endcase

    // Words 0 and 1 are the accumulators and are served without a memory cycle.
    if (go_rd)
    begin
      if (go_addr < ibu_pkg::ACC_WORDS)
      begin
        data_d  = (go_addr == ibu_pkg::ACC_A_WORD) ? a_q : b_q;
        state_d = ret_d;
      end
      else
      begin
        req_d = 1'b1; we_d = 1'b0; maddr_d = go_addr; state_d = S_RD;
      end
    end
    if (go_wr)
    begin
      if (go_addr == ibu_pkg::ACC_A_WORD)
      begin
        a_d = go_wdata; state_d = ret_d;
      end
      else if (go_addr == ibu_pkg::ACC_B_WORD)
      begin
        b_d = go_wdata; state_d = ret_d;
      end
      else
      begin
        req_d = 1'b1; we_d = 1'b1; maddr_d = go_addr; wdata_d = go_wdata; state_d = S_WR;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= S_IDLE;
      ret_q   <= S_IDLE;
      op_q    <= ibu_pkg::OP_LOAD_SECOND_INDEX;
      {a_q, b_q, x_q, y_q} <= {4{ibu_pkg::REG_RESET}};
      {p_q, m_q, ip_q, addr_q, data_q, cnt_q, w3_q, byte_q, req_q, we_q, maddr_q, wdata_q, busy_q, done_q,
       viol_q, intr_q} <= '0;
    end
    else
    begin
      state_q <= state_d;
      ret_q   <= ret_d;
      op_q    <= op_d;
      {a_q, b_q, x_q, y_q, p_q, m_q, ip_q, addr_q, data_q, cnt_q, w3_q, byte_q, req_q, we_q, maddr_q, wdata_q,
       busy_q, done_q, viol_q, intr_q} <= {a_d, b_d, x_d, y_d, p_d, m_d, ip_d, addr_d, data_d, cnt_d, w3_d,
       byte_d, req_d, we_d, maddr_d, wdata_d, busy_d, done_d, viol_d, intr_d};
    end
  end

  assign {mem_req, mem_we, mem_addr, mem_wdata, busy, done, viol, intr_exit, a_reg, b_reg, x_reg, y_reg, p_reg,
          m_reg} = {req_q, we_q, maddr_q, wdata_q, busy_q, done_q, viol_q, intr_q, a_q, b_q, x_q, y_q, p_q, m_q};

endmodule

// File: ibu_core_checker.sv
/* Port checker for ibu_core.
   Assumes it is bound onto every ibu_core instance. */
`timescale 1ns/1ps
module ibu_core_checker (
  input wire logic             clk,        // Clock
  input wire logic             rst_b,      // Reset, active low
  input wire logic             cmd_valid,  // Start pulse
  input wire ibu_pkg::ibu_op_e cmd_op,     // Operation
  input wire logic [14:0]      cmd_p,      // Location P
  input wire logic             protect_en, // Protection on
  input wire logic             mem_req,    // Request
  input wire logic [14:0]      mem_addr,   // Word address
  input wire logic             mem_ack,    // Acknowledge
  input wire logic             busy,       // Busy
  input wire logic             done,       // Done pulse
  input wire logic             viol,       // Violation pulse
  input wire logic [15:0]      a_reg,      // First accumulator
  input wire logic [15:0]      x_reg,      // First index
  input wire logic [15:0]      y_reg       // Second index
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Pending load byte and the location of the last accepted command.
  logic        take;
  logic        lb_q;
  logic        lb_d;
  logic [14:0] p_q;
  logic [14:0] p_d;
  assign take = cmd_valid && !busy;
  always_comb
  begin
    lb_d = take ? (cmd_op == ibu_pkg::OP_LOAD_BYTE) : (lb_q && !done);
    p_d  = take ? cmd_p : p_q;
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      lb_q <= 1'b0;
      p_q  <= 15'h0000;
    end
    else
    begin
      lb_q <= lb_d;
      p_q  <= p_d;
    end
  // ==========
  // Assertions.
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("Request moved early");
  a_ack_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("Request held past ack");
  a_done_once: assert property (done |=> !done)
    else $error("Done too long");
  a_viol_done: assert property (viol |=> done && !viol)
    else $error("No done after violation");
  a_viol_prot: assert property (viol |-> protect_en)
    else $error("Violation with protection off");
  a_swap_ax: assert property (take && cmd_op == ibu_pkg::OP_SWAP_A_FIRST_INDEX |=>
    a_reg == $past(x_reg) && x_reg == $past(a_reg) ##1 done) else $error("Swap of A and X wrong");
  a_link_ret: assert property (take && cmd_op == ibu_pkg::OP_SUBROUTINE_JUMP_LINK && !protect_en |->
    ##[2:40] (done && y_reg == 16'(p_q) + 16'h0002)) else $error("Link address wrong");
  a_lb_zero: assert property (lb_q && done |-> a_reg[15:8] == 8'h00)
    else $error("Load byte left upper half set");
endmodule
bind ibu_core ibu_core_checker u_chk (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_p(cmd_p), .protect_en(protect_en), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .busy(busy), .done(done), .viol(viol), .a_reg(a_reg), .x_reg(x_reg), .y_reg(y_reg));

// File: ibu_mem_model.sv
/* Word memory facing ibu_core, answering at once or after two wait cycles.
   Assumes the bench presets and inspects mem directly. */
`timescale 1ns/1ps
module ibu_mem_model (
  input  wire logic        clk,       // Clock
  input  wire logic        slow,      // Two wait cycles
  input  wire logic        mem_req,   // Request
  input  wire logic        mem_we,    // Write
  input  wire logic [14:0] mem_addr,  // Word address
  input  wire logic [15:0] mem_wdata, // Write data
  output logic      [15:0] mem_rdata, // Read data
  output logic             mem_ack    // Acknowledge
);
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_q = 2'h0;
  logic [15:0] last_q = 16'h0000;
  // Between answers the data lines show the inverse of the last word, so stale data cannot pass.
  assign mem_ack   = mem_req && (wait_q == (slow ? 2'h2 : 2'h0));
  assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_q;
  initial for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
  always @(posedge clk)
    if (mem_ack)
    begin
      wait_q <= 2'h0;
      last_q <= mem_rdata;
      if (mem_we)
        mem[mem_addr] <= mem_wdata;
    end
    else if (mem_req)
      wait_q <= wait_q + 2'h1;
endmodule

// File: ibu_core_tb.sv
/* Self-checking bench for ibu_core.
   Assumes the package, checker and memory model are compiled first. */
`timescale 1ns/1ps
module ibu_core_tb;
  logic             clk = 0, rst_b = 0, cmd_valid = 0, ld_en = 0, protect_en = 0, irq_req = 0, slow = 0;
  logic             mem_req, mem_we, mem_ack, busy, done, viol, intr_exit, sv, si;
  ibu_pkg::ibu_op_e cmd_op = ibu_pkg::OP_LOAD_BYTE;
  logic [1:0]       ld_sel = 2'h0;
  logic [14:0]      cmd_p = 15'h0000, fence = 15'h0000, mem_addr, p_reg, m_reg, ea;
  logic [15:0]      cmd_addr = 16'h0000, ld_data = 16'h0000, mem_wdata, mem_rdata, a_reg, b_reg, x_reg, y_reg;
  logic [15:0]      v, w, sa, db, n;
  integer           seed = 32'hFBD91DD9, bad_count = 0, compares = 0, k, j0;
  always #4 clk = ~clk;
  ibu_core dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_p(cmd_p), .cmd_addr(cmd_addr),
    .ld_en(ld_en), .ld_sel(ld_sel), .ld_data(ld_data), .fence(fence), .protect_en(protect_en), .irq_req(irq_req),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .busy(busy), .done(done), .viol(viol), .intr_exit(intr_exit), .a_reg(a_reg), .b_reg(b_reg),
    .x_reg(x_reg), .y_reg(y_reg), .p_reg(p_reg), .m_reg(m_reg));
  ibu_mem_model mdl (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ==========
  // Helpers.
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("Counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, e);
    compares++;
    bad_count += int'(g !== e);
    if (g !== e)
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic ld(input logic [1:0] s, input logic [15:0] d);
    ld_sel = s;
    ld_data = d;
    ld_en = 1'b1;
    tick;
    ld_en = 1'b0;
  endtask
  // Memory stalls are chosen anew for every command.
  task automatic run(input ibu_pkg::ibu_op_e op, input logic [14:0] p, input logic [15:0] a);
    slow = 1'($random(seed));
    cmd_op = op;
    cmd_p = p;
    cmd_addr = a;
    cmd_valid = 1'b1;
    sv = 1'b0;
    si = 1'b0;
    tick;
    cmd_valid = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++)
    begin
      sv |= viol;
      si |= intr_exit;
      tick;
    end
    bad_count += int'(done !== 1'b1);
    if (done !== 1'b1)
      give_verdict;
  endtask
  function automatic logic [7:0] rb(input logic [15:0] ba);
    return ba[0] ? mdl.mem[ba[15:1]][7:0] : mdl.mem[ba[15:1]][15:8];
  endfunction
  task automatic wb(input logic [15:0] ba, input logic [7:0] d);
    if (ba[0])
      mdl.mem[ba[15:1]][7:0] = d;
    else
      mdl.mem[ba[15:1]][15:8] = d;
  endtask
  // ==========
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tick;
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($random(seed));
      w = 16'($random(seed));
      ld({1'b0, i[1]}, v);
      ld({1'b1, i[0]}, w);
      run(ibu_pkg::ibu_op_e'(8 + i), 15'h0040, 16'h0000);
      chk(i[1] ? b_reg : a_reg, w);
      chk(i[0] ? y_reg : x_reg, v);
      v = 16'h8000 | (16'($random(seed)) & 16'h0FFF);
      n = 16'h1000 | (16'($random(seed)) & 16'h0FFF);
      ld({1'b1, i[0]}, v);
      run(ibu_pkg::ibu_op_e'(2 + i), 15'h0040, n);
      ea = 15'(n + v);
      chk(mdl.mem[ea], w);
      chk(16'(m_reg), 16'(ea));
      chk(i[0] ? y_reg : x_reg, v);
      chk(16'(p_reg), 16'h0042);
    end
    mdl.mem[15'h0200] = 16'h3000;
    ld(ibu_pkg::SEL_Y, 16'h0010);
    v = 16'($random(seed));
    mdl.mem[15'h3010] = v;
    run(ibu_pkg::OP_LOAD_B_INDEXED_SECOND, 15'h0040, 16'h8200);
    chk(b_reg, v);
    chk(16'(m_reg), 16'h3010);
    mdl.mem[15'h2222] = ~v;
    run(ibu_pkg::OP_LOAD_SECOND_INDEX, 15'h0040, 16'h2222);
    chk(y_reg, ~v);
    run(ibu_pkg::OP_LOAD_SECOND_INDEX, 15'h0040, 16'h0001);
    chk(y_reg, v);
    run(ibu_pkg::OP_STORE_SECOND_INDEX, 15'h0040, 16'h2300);
    chk(mdl.mem[15'h2300], v);
    ld(ibu_pkg::SEL_X, 16'h1357);
    run(ibu_pkg::OP_STORE_FIRST_INDEX, 15'h0040, 16'h0000);
    chk(a_reg, 16'h1357);
    $display("Test index finished");
    run(ibu_pkg::OP_SUBROUTINE_JUMP_LINK, 15'h0100, 16'h4000);
    chk(16'(p_reg), 16'h4000);
    chk(y_reg, 16'h0102);
    run(ibu_pkg::OP_INDEXED_RETURN_JUMP, 15'h4010, 16'h0005);
    chk(16'(p_reg), 16'h0107);
    chk(y_reg, 16'h0102);
    protect_en = 1'b1;
    fence = 15'h0010;
    run(ibu_pkg::OP_SUBROUTINE_JUMP_LINK, 15'h0300, 16'h0001);
    chk(16'(sv), 16'h0001);
    chk(16'(p_reg), 16'h0300);
    run(ibu_pkg::OP_INDEXED_RETURN_JUMP, 15'h0300, 16'h0020);
    chk(16'(sv), 16'h0000);
    chk(16'(p_reg), 16'h0122);
    mdl.mem[15'h6000] = 16'hA55A;
    mdl.mem[15'h6001] = 16'h9F00;
    ld(ibu_pkg::SEL_B, 16'hC001);
    run(ibu_pkg::OP_LOAD_BYTE, 15'h0050, 16'h0000);
    chk(a_reg, 16'h005A);
    run(ibu_pkg::OP_LOAD_BYTE, 15'h0050, 16'h0000);
    chk(a_reg, 16'h009F);
    chk(b_reg, 16'hC003);
    ld(ibu_pkg::SEL_B, 16'h0003);
    run(ibu_pkg::OP_LOAD_BYTE, 15'h0050, 16'h0000);
    chk({a_reg[15:1], sv}, 16'h0002);
    protect_en = 1'b0;
    $display("Test jump and byte finished");
    for (int c = 0; c < 4; c++)
    begin
      n = (16'($random(seed)) & 16'h0007) + 16'h0002;
      sa = 16'h6101;
      db = 16'h7000;
      j0 = int'(16'($random(seed)) % n);
      for (int j = 0; j < n; j++)
      begin
        v = 16'($random(seed));
        wb(sa + 16'(j), v[7:0]);
        wb(db + 16'(j), v[7:0]);
      end
      if (c == 1 || c == 2)
        wb(sa + 16'(j0), c == 1 ? 8'h10 : 8'hF0);
      if (c == 1 || c == 2)
        wb(db + 16'(j0), c == 1 ? 8'h90 : 8'h20);
      mdl.mem[15'h0400] = n;
      ld(ibu_pkg::SEL_A, sa);
      ld(ibu_pkg::SEL_B, db);
      irq_req = (c == 3);
      run(ibu_pkg::OP_BYTE_STRING_COMPARE, 15'h0500, 16'h0400);
      irq_req = 1'b0;
      if (c == 3)
      begin
        chk(16'(si), 16'h0001);
        chk(16'(p_reg), 16'h0500);
        chk(a_reg - sa + mdl.mem[15'h0502], n);
        run(ibu_pkg::OP_BYTE_STRING_COMPARE, 15'h0500, 16'h0400);
      end
      chk(16'(p_reg), 16'h0503 + (c == 3 ? 16'h0000 : 16'(c)));
      chk(a_reg, (c == 0 || c == 3) ? sa + n : sa + 16'(j0));
      chk(b_reg, db + n);
      chk(mdl.mem[15'h0502], 16'h0000);
    end
    $display("Test compare finished");
    sa = 16'h6201;
    db = 16'h7100;
    for (int j = 0; j < 11; j++)
      wb(sa + 16'(j), 8'(j * 37 + 5));
    mdl.mem[15'h0400] = 16'h000B;
    for (int r = 0; r < 2; r++)
    begin
      protect_en = (r == 1);
      fence = 15'h3900;
      ld(ibu_pkg::SEL_A, sa);
      ld(ibu_pkg::SEL_B, db);
      run(ibu_pkg::OP_BYTE_BLOCK_MOVE, 15'h0600, 16'h0400);
      chk(16'(sv), 16'(r));
      chk(16'(p_reg), r == 1 ? 16'h0600 : 16'h0603);
    end
    for (int j = 0; j < 11; j++)
      chk({8'h00, rb(db + 16'(j))}, 16'(j * 37 + 5) & 16'h00FF);
    $display("Test move finished");
    give_verdict;
  end
endmodule
